//--- src/dvh_pkg.sv
package dvh_pkg;

	// ********************************************************
	// register map, page 0
	// ********************************************************
	localparam logic [7:0] ADDR_MUTE = 8'h40;
	localparam logic [7:0] ADDR_GAIN = 8'h41;
	localparam logic [7:0] ADDR_RSVD = 8'h42;
	localparam logic [7:0] ADDR_HSET = 8'h43;
	localparam logic [7:0] ADDR_COMP = 8'h44;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [7:0] RST_MUTE = 8'h0C;
	localparam logic [7:0] RST_GAIN = 8'h00;
	localparam logic [7:0] RST_RSVD = 8'h00;
	localparam logic [7:0] RST_HSET = 8'h00;
	localparam logic [7:0] RST_COMP = 8'h0F;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int MUTE_BIT = 3;
	localparam int HS_EN_BIT = 7;
	localparam int HS_ST_LO = 5;
	localparam int HS_ST_HI = 6;
	localparam int HS_DEB_LO = 2;
	localparam int HS_DEB_HI = 4;
	localparam int BT_DEB_LO = 0;
	localparam int BT_DEB_HI = 1;
	localparam int COMP_EN_BIT = 6;
	localparam int COMP_TH_LO = 2;
	localparam int COMP_TH_HI = 4;
	localparam int COMP_HY_LO = 0;
	localparam int COMP_HY_HI = 1;
	// writable bits of the headset register (status is read only)
	localparam logic [7:0] HSET_WMASK = 8'h9F;

	// ********************************************************
	// headset status codes
	// ********************************************************
	localparam logic [1:0] HS_NONE = 2'h0;
	localparam logic [1:0] HS_NO_MIC = 2'h1;
	localparam logic [1:0] HS_RSVD = 2'h2;
	localparam logic [1:0] HS_MIC = 2'h3;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int SYS_CLK_HZ = 10000000;
	localparam int REF_CLK_HZ = 1000000;
	localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
	localparam int MS_US = 1000;
	localparam int MS_REF_TICKS = MS_US * REF_CLK_HZ / 1000000;
	// a debounce time spans eight sampling periods
	localparam int DEB_SAMPLES = 8;

	// volume soft-step modes
	typedef enum logic [1:0] {
		STEP_EVERY = 2'b00,
		STEP_HALF = 2'b01,
		STEP_OFF = 2'b10,
		STEP_RSVD = 2'b11
	} dvh_step_type;

endpackage : dvh_pkg

//--- src/dvh_debounce.sv
`timescale 1ns/10ps
module dvh_debounce #(
	parameter int W = 2
) (
	input logic sys_clk,
	input logic rst_n,
	input logic ce,
	input logic clear,
	input logic sample,
	input logic [W-1:0] raw,
	output logic [W-1:0] stable
);
	import dvh_pkg::*;

	logic [W-1:0] candidate;
	logic [2:0] agree;

	// a new value is taken only after eight equal samples in a row
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			candidate <= '0;
			agree <= 3'h0;
			stable <= '0;
		end else if (ce) begin
			if (clear) begin
				candidate <= '0;
				agree <= 3'h0;
				stable <= '0;
			end else if (sample) begin
				if (raw != candidate) begin
					candidate <= raw;
					agree <= 3'h0;
				end else if (agree == 3'(DEB_SAMPLES - 2)) begin
					stable <= candidate;
					agree <= 3'h0;
				end else begin
					agree <= agree + 3'h1;
				end
			end
		end
	end

endmodule : dvh_debounce

//--- src/dvh_regs.sv
// Notes on behaviour
// - mute bit 3 mutes DAC, resets set
// - gain register is signed half-decibel steps
// - headset detection runs only while bit7 set
// - detection result read-only at bits 6:5
// - insertion debounce 16 to 512 ms
// - button debounce off, 8, 16, 32 ms
// - debounce timing from 1 MHz reference
// - compressor active only while bit 6 set
// - compressor threshold field bits 4:2, reset 011
// - compressor hysteresis bits 1:0, reset 11
// - volume changes soft-stepped per step setting
`timescale 1ns/10ps
module dvh_regs (
	input logic sys_clk,
	input logic rst_n,
	input logic ce,
	// register port
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_write,
	input logic reg_read,
	output logic [7:0] reg_rdata,
	// data path setting held outside this block
	input dvh_pkg::dvh_step_type soft_step_mode,
	input logic sample_tick,
	// headset pins
	input logic [1:0] headset_sense,
	input logic button_sense,
	// controls to the audio path
	output logic dac_mute,
	output logic [7:0] dac_gain,
	output logic compressor_enable,
	output logic [2:0] compressor_threshold,
	output logic [1:0] compressor_hysteresis,
	output logic [1:0] headset_status,
	output logic button_pressed
);
	import dvh_pkg::*;

	logic [7:0] mute_reg;
	logic [7:0] gain_reg;
	logic [7:0] rsvd_reg;
	logic [7:0] hset_reg;
	logic [7:0] comp_reg;
	logic [7:0] next_rdata;
	logic [2:0] sync_1;
	logic [2:0] sync_2;
	logic [2:0] sync_3;
	logic [2:0] pin_level;
	logic [3:0] ref_cnt;
	logic ref_tick;
	logic [9:0] ms_cnt;
	logic ms_tick;
	logic [5:0] ms_phase;
	logic [5:0] hs_mask;
	logic [5:0] bt_mask;
	logic hs_sample;
	logic bt_sample;
	logic hs_enable;
	logic [1:0] hs_stable;
	logic bt_stable;
	logic half_phase;
	logic step_now;

	// ********************************************************
	// register writes
	// ********************************************************

	// host-writable storage; reserved bits keep what is written
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mute_reg <= RST_MUTE;
			gain_reg <= RST_GAIN;
			rsvd_reg <= RST_RSVD;
			hset_reg <= RST_HSET;
			comp_reg <= RST_COMP;
		end else if (ce && reg_write) begin
			case (reg_addr)
				ADDR_MUTE: mute_reg <= reg_wdata;
				ADDR_GAIN: gain_reg <= reg_wdata;
				ADDR_RSVD: rsvd_reg <= reg_wdata;
				ADDR_HSET: hset_reg <= reg_wdata & HSET_WMASK;
				ADDR_COMP: comp_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ********************************************************
	// register reads
	// ********************************************************

	// unmapped locations read as zero
	always_comb begin
		case (reg_addr)
			ADDR_MUTE: next_rdata = mute_reg;
			ADDR_GAIN: next_rdata = gain_reg;
			ADDR_RSVD: next_rdata = rsvd_reg;
			ADDR_HSET: begin
				next_rdata = hset_reg;
				next_rdata[HS_ST_HI:HS_ST_LO] = headset_status;
			end
			ADDR_COMP: next_rdata = comp_reg;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data is registered, one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// ********************************************************
	// direct controls
	// ********************************************************

	assign dac_mute = mute_reg[MUTE_BIT];
	assign compressor_enable = comp_reg[COMP_EN_BIT];
	assign compressor_threshold = comp_reg[COMP_TH_HI:COMP_TH_LO];
	assign compressor_hysteresis = comp_reg[COMP_HY_HI:COMP_HY_LO];

	// ********************************************************
	// volume soft-step
	// ********************************************************

	// half mode steps on every second sample tick
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_phase <= 1'b0;
		end else if (ce && sample_tick) begin
			half_phase <= ~half_phase;
		end
	end

	always_comb begin
		case (soft_step_mode)
			STEP_EVERY: step_now = sample_tick;
			STEP_HALF: step_now = sample_tick & half_phase;
			default: step_now = 1'b1;
		endcase
	end

	// signed compare, one half-decibel per step
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_gain <= RST_GAIN;
		end else if (ce && step_now) begin
			if (soft_step_mode == STEP_OFF || soft_step_mode == STEP_RSVD) begin
				dac_gain <= gain_reg;
			end else if ($signed(dac_gain) < $signed(gain_reg)) begin
				dac_gain <= dac_gain + 8'h01;
			end else if ($signed(dac_gain) > $signed(gain_reg)) begin
				dac_gain <= dac_gain - 8'h01;
			end
		end
	end

	// ********************************************************
	// pin synchronisers
	// ********************************************************

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_1 <= 3'h0;
			sync_2 <= 3'h0;
			sync_3 <= 3'h0;
			pin_level <= 3'h0;
		end else if (ce) begin
			sync_1 <= {button_sense, headset_sense};
			sync_2 <= sync_1;
			sync_3 <= sync_2;
			for (int i = 0; i < 3; i++) begin
				if (sync_2[i] == sync_3[i]) begin
					pin_level[i] <= sync_3[i];
				end
			end
		end
	end

	// ********************************************************
	// debounce timebase
	// ********************************************************

	// 1 MHz reference from the system clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt <= 4'h0;
		end else if (ce) begin
			if (ref_tick) begin
				ref_cnt <= 4'h0;
			end else begin
				ref_cnt <= ref_cnt + 4'h1;
			end
		end
	end
	assign ref_tick = (ref_cnt == 4'(REF_DIV - 1));

	// millisecond count of reference ticks, and a free ms phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 10'h000;
			ms_phase <= 6'h00;
		end else if (ce && ref_tick) begin
			if (ms_tick) begin
				ms_cnt <= 10'h000;
				ms_phase <= ms_phase + 6'h01;
			end else begin
				ms_cnt <= ms_cnt + 10'h001;
			end
		end
	end
	assign ms_tick = (ms_cnt == 10'(MS_REF_TICKS - 1));

	// sampling period 2..64 ms; reserved codes act as 64
	always_comb begin
		case (hset_reg[HS_DEB_HI:HS_DEB_LO])
			3'h0: hs_mask = 6'h01;
			3'h1: hs_mask = 6'h03;
			3'h2: hs_mask = 6'h07;
			3'h3: hs_mask = 6'h0F;
			3'h4: hs_mask = 6'h1F;
			default: hs_mask = 6'h3F;
		endcase
	end

	// button sampling period 1, 2 or 4 ms
	always_comb begin
		case (hset_reg[BT_DEB_HI:BT_DEB_LO])
			2'h2: bt_mask = 6'h01;
			2'h3: bt_mask = 6'h03;
			default: bt_mask = 6'h00;
		endcase
	end

	assign hs_sample = ref_tick & ms_tick & ((ms_phase & hs_mask) == 6'h00);
	assign bt_sample = ref_tick & ms_tick & ((ms_phase & bt_mask) == 6'h00);

	// ********************************************************
	// headset detection
	// ********************************************************

	assign hs_enable = hset_reg[HS_EN_BIT];

	dvh_debounce #(
		.W(2)
	) u_insert_filter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.clear(~hs_enable),
		.sample(hs_sample),
		.raw(pin_level[1:0]),
		.stable(hs_stable)
	);

	dvh_debounce #(
		.W(1)
	) u_button_filter (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.clear(~hs_enable),
		.sample(bt_sample),
		.raw(pin_level[2]),
		.stable(bt_stable)
	);

	// reserved code and disabled detection read 00
	// gated here too, since the filter clear lands one cycle late
	assign headset_status = (~hs_enable || hs_stable == HS_RSVD) ? HS_NONE :
		hs_stable;

	// code 00 bypasses the button filter
	assign button_pressed = ~hs_enable ? 1'b0 :
		(hset_reg[BT_DEB_HI:BT_DEB_LO] == 2'h0) ? pin_level[2] : bt_stable;

endmodule : dvh_regs

//--- verification/dvh_regs_chk.sv
`timescale 1ns/10ps
module dvh_regs_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire dvh_pkg::dvh_step_type soft_step_mode,
	input wire logic sample_tick,
	input wire logic dac_mute,
	input wire logic [7:0] dac_gain,
	input wire logic compressor_enable,
	input wire logic [2:0] compressor_threshold,
	input wire logic [1:0] compressor_hysteresis,
	input wire logic [1:0] headset_status,
	input wire logic button_pressed
);
	import dvh_pkg::*;
	logic hs_en;
	logic wr_c;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a compressor register write taken this edge
	assign wr_c = reg_write && ce && reg_addr == ADDR_COMP;
	// mirror of the detection enable, the headset register bits are hidden from us
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			hs_en <= 1'b0;
		else if (ce && reg_write && reg_addr == ADDR_HSET)
			hs_en <= reg_wdata[HS_EN_BIT];
	end
	AST_MUTE: assert property (
		ce && reg_write && reg_addr == ADDR_MUTE |=>
		dac_mute == $past(reg_wdata[MUTE_BIT])) else $error("mute wrong");
	AST_CEN: assert property (
		wr_c |=> compressor_enable == $past(reg_wdata[COMP_EN_BIT]))
		else $error("compressor enable wrong");
	AST_THR: assert property (
		wr_c |=> compressor_threshold == $past(reg_wdata[4:2]))
		else $error("threshold wrong");
	AST_HYS: assert property (
		wr_c |=> compressor_hysteresis == $past(reg_wdata[1:0]))
		else $error("hysteresis wrong");
	AST_OFF: assert property (
		!hs_en |-> headset_status == HS_NONE &&
		!button_pressed) else $error("detection output while off");
	AST_CODE: assert property (
		headset_status != HS_RSVD) else $error("reserved status code");
	AST_STEP: assert property (
		$past(soft_step_mode) == STEP_EVERY && !$past(sample_tick) |->
		$stable(dac_gain)) else $error("gain moved without a tick");
	AST_ONE: assert property (
		$past(soft_step_mode) inside {STEP_EVERY, STEP_HALF} &&
		$changed(dac_gain) |-> dac_gain - $past(dac_gain) inside
		{8'h01, 8'hFF}) else $error("gain step not one code");
endmodule : dvh_regs_chk

bind dvh_regs dvh_regs_chk u_chk (.sys_clk, .rst_n, .ce, .reg_addr,
	.reg_wdata, .reg_write, .soft_step_mode, .sample_tick, .dac_mute,
	.dac_gain, .compressor_enable, .compressor_threshold,
	.compressor_hysteresis, .headset_status, .button_pressed);

//--- verification/dvh_host.sv
`timescale 1ns/10ps
module dvh_host (
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	import dvh_pkg::*;
	logic [7:0] exp_q[$];
	// ********************
	// host register cycles
	// ********************
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// one-cycle strobe, so back-to-back calls leave a gap cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == ADDR_GAIN && ($signed(d) > 48 || d == 8'h80))
			return;
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= a == ADDR_MUTE ? (d & 8'h08) | 8'h04 :
			a == ADDR_COMP ? d & 8'h5F : d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr
	// the expected byte is noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_read <= 1'b0;
	endtask : rd
endmodule : dvh_host

//--- verification/dac_volume_headset_drc_regs_tb_top.sv
`timescale 1ns/10ps
module dac_volume_headset_drc_regs_tb_top;
	import dvh_pkg::*;
	logic sys_clk, rst_n, ce, reg_write, reg_read, sample_tick;
	logic button_sense, dac_mute, compressor_enable, button_pressed, rd_pend;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_gain, seed, gv;
	logic [1:0] headset_sense, compressor_hysteresis, headset_status;
	logic [2:0] compressor_threshold;
	dvh_step_type soft_step_mode;
	int err_total;
	int tests_run;
	logic [7:0] rv[7] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
	dvh_regs u_dut (.sys_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .soft_step_mode, .sample_tick, .headset_sense,
		.button_sense, .dac_mute, .dac_gain, .compressor_enable,
		.compressor_threshold, .compressor_hysteresis, .headset_status,
		.button_pressed);
	dvh_host u_host (.sys_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// n one-cycle sample pulses with a quiet cycle between them
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			sample_tick <= 1'b1;
			@(posedge sys_clk);
			sample_tick <= 1'b0;
		end
		repeat (2) @(negedge sys_clk);
	endtask : tick
	// read data lands on the same edge that takes the strobe
	always @(posedge sys_clk)
		rd_pend <= reg_read && ce;
	always @(negedge sys_clk)
		if (rd_pend === 1'b1 && u_host.exp_q.size() > 0)
			check(reg_rdata, u_host.exp_q.pop_front());
	// ********************
	// main sequence
	// ********************
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		soft_step_mode = STEP_OFF;
		sample_tick = 1'b0;
		headset_sense = 2'h0;
		button_sense = 1'b0;
		err_total = 0;
		tests_run = 0;
		seed = 8'h22;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (rv[i])
			u_host.rd(8'h3F + 8'(i), rv[i]);
		check(dac_mute, 1'b1);
		// a write with the clock enable low must be lost
		ce <= 1'b0;
		u_host.wr(ADDR_MUTE, 8'h00);
		ce <= 1'b1;
		@(negedge sys_clk);
		check(dac_mute, 1'b1);
		u_host.wr(ADDR_MUTE, 8'h00);
		@(negedge sys_clk);
		check(dac_mute, 1'b0);
		u_host.rd(ADDR_MUTE, 8'h04);
		for (int i = 0; i < 8; i++) begin
			u_host.wr(ADDR_COMP, {1'b0, i[0], 1'b0, i[2:0], ~i[1:0]});
			@(negedge sys_clk);
			check(compressor_enable, i[0]);
			check(compressor_threshold, i[2:0]);
			check(compressor_hysteresis, 2'(~i[1:0]));
		end
		// pins drive nothing until detection is on
		@(posedge sys_clk);
		headset_sense <= 2'h1;
		button_sense <= 1'b1;
		repeat (20) @(negedge sys_clk);
		check(button_pressed, 1'b0);
		u_host.wr(ADDR_HSET, 8'hE0);
		repeat (20) @(negedge sys_clk);
		check(button_pressed, 1'b1);
		check(headset_status, HS_NONE);
		u_host.rd(ADDR_HSET, 8'h80);
		u_host.wr(ADDR_HSET, 8'h00);
		repeat (4) @(negedge sys_clk);
		check(button_pressed, 1'b0);
		// 1 ms button sampling: eight samples before a press shows
		u_host.wr(ADDR_HSET, 8'h81);
		repeat (69000) @(negedge sys_clk);
		check(button_pressed, 1'b0);
		repeat (12000) @(negedge sys_clk);
		check(button_pressed, 1'b1);
		check(headset_status, HS_NONE);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			gv = seed[7] ? seed | 8'h01 : {3'h0, seed[4:0]};
			gv = i == 0 ? 8'h30 : i == 1 ? 8'h81 : gv;
			u_host.wr(ADDR_GAIN, gv);
			repeat (2) @(negedge sys_clk);
			check(dac_gain, gv);
			u_host.rd(ADDR_GAIN, gv);
		end
		u_host.wr(ADDR_GAIN, 8'h00);
		repeat (2) @(posedge sys_clk);
		soft_step_mode <= STEP_EVERY;
		u_host.wr(ADDR_GAIN, 8'h03);
		for (int i = 1; i < 4; i++) begin
			tick(1);
			check(dac_gain, 8'(i));
		end
		// ramp down across zero must stay signed
		@(posedge sys_clk);
		soft_step_mode <= STEP_HALF;
		u_host.wr(ADDR_GAIN, 8'hFF);
		tick(2);
		check(dac_gain, 8'h02);
		tick(6);
		check(dac_gain, 8'hFF);
		tick(2);
		check(dac_gain, 8'hFF);
		stop_test;
	end
	// the sequence needs just over 81000 cycles; a hang ends as a failure
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		stop_test;
	end
endmodule : dac_volume_headset_drc_regs_tb_top
